// File: src/sfc_fifo.sv
`timescale 1ns/1ps
module sfc_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_reg;
    logic [AW:0] rdPtr_reg;
    logic doPush;
    logic doPop;

    assign inReady = (wrPtr_reg[AW] == rdPtr_reg[AW]) || (wrPtr_reg[AW-1:0] != rdPtr_reg[AW-1:0]);
    assign outValid = wrPtr_reg != rdPtr_reg;
    assign outData = mem[rdPtr_reg[AW-1:0]];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    always_ff @(posedge clock) begin
        if (reset) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            if (doPush) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doPop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (doPush) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end
endmodule : sfc_fifo

// File: src/sfc_front_end.sv
`timescale 1ns/1ps
module sfc_front_end
    import sfc_pkg::*;
#(
    parameter int FIFO_DEPTH_P = FIFO_DEPTH,
    parameter int BUF_BYTES_P = BUF_BYTES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    output logic so,
    output logic soOe,
    input wire logic wpN,
    input wire logic resetN,
    output logic busyOut,
    output logic busyOe,
    output logic spiModeHigh,
    output logic opStart,
    output logic [13:0] opKind,
    output logic [PAGE_BITS-1:0] opPage,
    output logic opBuffer,
    output logic opAbort,
    input wire logic opDone,
    input wire logic compareMismatch,
    output logic rdReq,
    output logic rdFromArray,
    output logic rdBuffer,
    output logic [PAGE_BITS-1:0] rdPage,
    output logic [BUF_ADDR_BITS-1:0] rdAddr,
    input wire logic [7:0] rdData,
    output logic wrValid,
    input wire logic wrReady,
    output logic wrBuffer,
    output logic [BUF_ADDR_BITS-1:0] wrAddr,
    output logic [7:0] wrData,
    output logic writeOverrun
);
    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [1:0] csSync_reg, sckSync_reg, siSync_reg, wpSync_reg, rstSync_reg;
    logic csPrev_reg, sckPrev_reg;
    logic csFall, csRise, sckRise, sckFall, pinReset, siBit;

    always_ff @(posedge clock) begin
        if (reset) begin
            csSync_reg <= 2'h3;
            sckSync_reg <= 2'h3;
            siSync_reg <= 2'h0;
            wpSync_reg <= 2'h0;
            rstSync_reg <= 2'h3;
            csPrev_reg <= 1'b1;
            sckPrev_reg <= 1'b1;
        end else begin
            csSync_reg <= {csSync_reg[0], csN};
            sckSync_reg <= {sckSync_reg[0], sck};
            siSync_reg <= {siSync_reg[0], si};
            wpSync_reg <= {wpSync_reg[0], wpN};
            rstSync_reg <= {rstSync_reg[0], resetN};
            csPrev_reg <= csSync_reg[1];
            sckPrev_reg <= sckSync_reg[1];
        end
    end

    assign csFall = csPrev_reg && !csSync_reg[1];
    assign csRise = !csPrev_reg && csSync_reg[1];
    assign sckRise = !sckPrev_reg && sckSync_reg[1];
    assign sckFall = sckPrev_reg && !sckSync_reg[1];
    assign pinReset = !rstSync_reg[1];
    assign siBit = siSync_reg[1];

    // ----------------------------------------------------------------
    // clock mode
    // ----------------------------------------------------------------
    logic cpol_reg;

    always_ff @(posedge clock) begin
        if (reset || pinReset) begin
            cpol_reg <= CPOL_RESET;
        end else if (csFall) begin
            cpol_reg <= sckSync_reg[1];
        end
    end

    // ----------------------------------------------------------------
    // command framing
    // ----------------------------------------------------------------
    sfc_sess_type sess_reg;
    sfc_op_type opState_reg;
    sfc_cmd_type cmd_reg, opKind_reg, decodeNow, kindEff;
    logic [15:0] bitCnt_reg, bitNext;
    logic [31:0] rxShift_reg;
    logic [7:0] opcNow;
    logic bufSel_reg, engagedBuf_reg, opBusy, engaged, refuseNow, atOpcode;
    logic reqByte, pushNow, fifoInReady, fifoOutValid, launchOk, protectHit;
    logic [PAGE_BITS-1:0] page_reg;
    logic [BUF_ADDR_BITS-1:0] addr_reg;
    logic [23:0] addrField;

    assign bitNext = (bitCnt_reg == 16'hffff) ? bitCnt_reg : bitCnt_reg + 16'h1;
    assign opcNow = {rxShift_reg[6:0], siBit};
    assign decodeNow = decodeOpcode(opcNow);
    assign atOpcode = sckRise && sess_reg == S_SHIFT && bitNext == 16'(OPCODE_BITS);
    assign kindEff = atOpcode ? decodeNow : cmd_reg;
    assign opBusy = opState_reg != O_IDLE;
    assign engaged = opBusy && engagesBuffer(opKind_reg);
    // a busy array refuses array work and the engaged buffer, nothing else
    assign refuseNow = decodeNow == CMD_NONE
        || (opBusy && isArrayCmd(decodeNow))
        || (engaged && decodeNow inside {CMD_BUF_READ, CMD_BUF_WRITE}
            && bufferTwo(opcNow) == engagedBuf_reg);
    assign addrField = {rxShift_reg[22:0], siBit};

    always_ff @(posedge clock) begin
        if (reset || pinReset) begin
            sess_reg <= S_IDLE;
            bitCnt_reg <= '0;
            rxShift_reg <= '0;
            cmd_reg <= CMD_NONE;
            bufSel_reg <= 1'b0;
        end else begin
            case (sess_reg)
                S_IDLE: begin
                    if (csFall) begin
                        sess_reg <= S_SHIFT;
                        bitCnt_reg <= '0;
                        cmd_reg <= CMD_NONE;
                    end
                end
                S_SHIFT: begin
                    if (csRise) begin
                        sess_reg <= S_IDLE;
                    end else if (sckRise) begin
                        rxShift_reg <= {rxShift_reg[30:0], siBit};
                        bitCnt_reg <= bitNext;
                        if (atOpcode) begin
                            cmd_reg <= decodeNow;
                            bufSel_reg <= bufferTwo(opcNow);
                            if (refuseNow) begin
                                sess_reg <= S_IGNORE;
                            end
                        end
                    end
                end
                S_IGNORE: begin
                    if (csRise) begin
                        sess_reg <= S_IDLE;
                    end
                end
                default: sess_reg <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // addressing and byte requests
    // ----------------------------------------------------------------
    logic rdReq_reg, rdFromArray_reg, rdBuffer_reg, loadNext_reg;
    logic [PAGE_BITS-1:0] rdPage_reg;
    logic [BUF_ADDR_BITS-1:0] rdAddr_reg, addrInc;
    logic addrWrap;

    assign reqByte = sckRise && sess_reg == S_SHIFT && !(atOpcode && refuseNow)
        && isReadCmd(kindEff) && bitNext >= dataStart(kindEff) && bitNext[2:0] == 3'h0;
    assign pushNow = sckRise && sess_reg == S_SHIFT && cmd_reg inside {CMD_BUF_WRITE,
        CMD_PROG_THRU} && bitNext > 16'(HEADER_BITS) && bitNext[2:0] == 3'h0;
    assign addrWrap = addr_reg == BUF_ADDR_BITS'(BUF_BYTES_P - 1);
    assign addrInc = addrWrap ? '0 : addr_reg + 1'b1;

    always_ff @(posedge clock) begin
        if (reset || pinReset) begin
            page_reg <= '0;
            addr_reg <= '0;
            rdReq_reg <= 1'b0;
            rdFromArray_reg <= 1'b0;
            rdBuffer_reg <= 1'b0;
            rdPage_reg <= '0;
            rdAddr_reg <= '0;
            loadNext_reg <= 1'b0;
        end else begin
            rdReq_reg <= 1'b0;
            loadNext_reg <= rdReq_reg;
            if (sckRise && sess_reg == S_SHIFT && bitNext == 16'(HEADER_BITS)) begin
                // reserved pair, page field, then buffer byte address
                page_reg <= addrField[PAGE_LSB +: PAGE_BITS];
                addr_reg <= addrField[BUF_ADDR_BITS-1:0];
            end else if ((reqByte && kindEff != CMD_STATUS) || pushNow) begin
                addr_reg <= addrInc;
                if (addrWrap && cmd_reg == CMD_CONT_READ) begin
                    page_reg <= page_reg + 1'b1;
                end
            end
            if (reqByte && kindEff != CMD_STATUS) begin
                rdReq_reg <= 1'b1;
                rdFromArray_reg <= isArrayCmd(kindEff);
                rdBuffer_reg <= bufSel_reg;
                rdPage_reg <= page_reg;
                rdAddr_reg <= addr_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // serial output
    // ----------------------------------------------------------------
    logic [7:0] txShift_reg, statusByte;
    logic so_reg, soOe_reg, soActive_reg, cmpFlag_reg;

    always_comb begin
        statusByte = 8'h00;
        statusByte[STATUS_READY_BIT] = !opBusy;
        statusByte[STATUS_COMPARE_BIT] = cmpFlag_reg;
    end

    always_ff @(posedge clock) begin
        if (reset || pinReset || sess_reg != S_SHIFT) begin
            txShift_reg <= '0;
            so_reg <= 1'b0;
            soActive_reg <= 1'b0;
            soOe_reg <= 1'b0;
        end else begin
            // a falling edge before the first data request never shifts, so mode 3 is safe
            if (reqByte) begin
                soActive_reg <= 1'b1;
            end
            if (reqByte && kindEff == CMD_STATUS) begin
                txShift_reg <= statusByte;
            end else if (loadNext_reg) begin
                txShift_reg <= rdData;
            end else if (sckFall && soActive_reg) begin
                so_reg <= txShift_reg[7];
                txShift_reg <= {txShift_reg[6:0], 1'b0};
            end
            soOe_reg <= soActive_reg && !csSync_reg[1];
        end
    end

    // ----------------------------------------------------------------
    // write data buffering
    // ----------------------------------------------------------------
    logic overrun_reg, fifoClear_reg;
    logic [FIFO_WIDTH-1:0] fifoOut;

    always_ff @(posedge clock) begin
        if (reset) begin
            overrun_reg <= 1'b0;
            fifoClear_reg <= 1'b1;
        end else begin
            fifoClear_reg <= pinReset;
            // a lost byte sets the flag even on the cycle a new frame clears it
            if (pushNow && !fifoInReady) begin
                overrun_reg <= 1'b1;
            end else if (csFall) begin
                overrun_reg <= 1'b0;
            end
        end
    end

    sfc_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH_P)
    ) writeFifo (
        .clock(clock),
        .reset(fifoClear_reg),
        .inValid(pushNow),
        .inReady(fifoInReady),
        .inData({bufSel_reg, addr_reg, opcNow}),
        .outValid(fifoOutValid),
        .outReady(wrReady),
        .outData(fifoOut)
    );

    // ----------------------------------------------------------------
    // self-timed array operations
    // ----------------------------------------------------------------
    logic opStart_reg, busyOe_reg, opAbort_reg;
    logic [PAGE_BITS-1:0] opPage_reg;

    assign protectHit = isProgram(cmd_reg) && !wpSync_reg[1] && page_reg < PROTECT_PAGES;
    assign launchOk = csRise && sess_reg == S_SHIFT && bitCnt_reg >= 16'(HEADER_BITS)
        && isSelfTimed(cmd_reg) && !protectHit && !opBusy;

    always_ff @(posedge clock) begin
        if (reset || pinReset) begin
            opState_reg <= O_IDLE;
            opKind_reg <= CMD_NONE;
            opPage_reg <= '0;
            engagedBuf_reg <= 1'b0;
            opStart_reg <= 1'b0;
            busyOe_reg <= 1'b0;
            cmpFlag_reg <= 1'b0;
        end else begin
            opStart_reg <= 1'b0;
            case (opState_reg)
                O_IDLE: begin
                    if (launchOk) begin
                        opState_reg <= O_DRAIN;
                        opKind_reg <= cmd_reg;
                        opPage_reg <= page_reg;
                        engagedBuf_reg <= bufSel_reg;
                        busyOe_reg <= 1'b1;
                    end
                end
                O_DRAIN: begin
                    // programming waits until every buffered byte has reached the buffer
                    if (!fifoOutValid) begin
                        opState_reg <= O_RUN;
                        opStart_reg <= 1'b1;
                    end
                end
                O_RUN: begin
                    if (opDone) begin
                        opState_reg <= O_IDLE;
                        busyOe_reg <= 1'b0;
                        if (opKind_reg == CMD_COMPARE) begin
                            cmpFlag_reg <= compareMismatch;
                        end
                    end
                end
                default: opState_reg <= O_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            opAbort_reg <= 1'b0;
        end else begin
            opAbort_reg <= pinReset;
        end
    end

    assign so = so_reg;
    assign soOe = soOe_reg;
    assign busyOut = 1'b0;
    assign busyOe = busyOe_reg;
    assign spiModeHigh = cpol_reg;
    assign opStart = opStart_reg;
    assign opKind = opKind_reg;
    assign opPage = opPage_reg;
    assign opBuffer = engagedBuf_reg;
    assign opAbort = opAbort_reg;
    assign rdReq = rdReq_reg;
    assign rdFromArray = rdFromArray_reg;
    assign rdBuffer = rdBuffer_reg;
    assign rdPage = rdPage_reg;
    assign rdAddr = rdAddr_reg;
    assign wrValid = fifoOutValid;
    assign {wrBuffer, wrAddr, wrData} = fifoOut;
    assign writeOverrun = overrun_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_so_float_deselect: assert property (csSync_reg[1] |=> !soOe_reg)
        else $error("output driven while deselected");
    a_busy_pin_tracks: assert property (opState_reg == O_RUN |-> busyOe_reg)
        else $error("busy pin released during operation");
    a_launch_on_rise: assert property (launchOk && !pinReset |=> opState_reg == O_DRAIN)
        else $error("operation not started at select rise");
    a_protect_refuse: assert property (csRise && sess_reg == S_SHIFT && protectHit
        && !opBusy |=> opState_reg == O_IDLE ##1 !opStart_reg)
        else $error("protected page accepted");
    a_pin_reset_idle: assert property (pinReset |=> sess_reg == S_IDLE && !opBusy
        && spiModeHigh)
        else $error("reset pin did not idle the device");
    a_mode_sampled: assert property (csFall && !pinReset
        |=> cpol_reg == $past(sckSync_reg[1]))
        else $error("clock mode not sampled at select fall");
    a_array_refused: assert property (atOpcode && opBusy && isArrayCmd(decodeNow)
        && !pinReset |=> sess_reg == S_IGNORE)
        else $error("array command accepted while busy");
    a_status_allowed: assert property (atOpcode && decodeNow == CMD_STATUS && !pinReset
        |=> sess_reg == S_SHIFT && soActive_reg)
        else $error("status read refused");
    a_compare_result: assert property (opState_reg == O_RUN && opDone && !pinReset
        && opKind_reg == CMD_COMPARE |=> cmpFlag_reg == $past(compareMismatch))
        else $error("compare result not stored");
    a_fall_shift: assert property (sess_reg == S_SHIFT && soActive_reg && sckFall
        && !loadNext_reg && !csRise && !pinReset |=> so_reg == $past(txShift_reg[7]))
        else $error("output bit not shifted on falling edge");
    a_start_after_drain: assert property (opStart_reg |-> $past(opState_reg == O_DRAIN)
        && !$past(fifoOutValid))
        else $error("start issued with data pending");

    c_status_read: cover property (atOpcode && decodeNow == CMD_STATUS);
    c_buffer_push: cover property (pushNow && fifoInReady);
    c_op_done: cover property (opState_reg == O_RUN && opDone);
    c_group_b_busy: cover property (atOpcode && opBusy && !refuseNow);
endmodule : sfc_front_end

// File: src/sfc_pkg.sv
// Behaviour
// - status and unengaged buffer commands run during array work
// - sample input on rising, shift output falling
// - deselected: ignore input, output floats
// - chip select fall starts, rise ends commands
// - protect low blocks program/erase of 256 pages
// - reset pin aborts work and holds idle
// - busy pin pulled low during self-timed work
// - busy blocks array and engaged buffer only
// - after reset: mode 3, output floats, await select
// - clock mode sampled at each select fall
// - continuous read 68/e8, page read 52/d2
// - buffer reads 54/d4, 56/d6; status 57/d7
// - buffer writes 84 and 87, any mode
// - program with erase 83 and 86
// - program without erase 88 and 89
// - through-buffer 82/85, page erase 81, block 50
// - page to buffer transfer 53 and 55
// - page to buffer compare 60 and 61
// - auto rewrite 58 and 59
// - two reserved, 12 page, 10 buffer bits
// - self-timed work starts on select rise
// - compare result lands in status bit 6
package sfc_pkg;
    localparam int OPCODE_BITS = 8;
    localparam int HEADER_BITS = 32;
    localparam int BUF_DATA_START = 40;
    localparam int ARRAY_DATA_START = 64;
    localparam int PAGE_BITS = 12;
    localparam int PAGE_LSB = 10;
    localparam int BUF_ADDR_BITS = 10;
    localparam int BUF_BYTES = 528;
    localparam logic [PAGE_BITS-1:0] PROTECT_PAGES = 12'h100;
    localparam int STATUS_READY_BIT = 7;
    localparam int STATUS_COMPARE_BIT = 6;
    localparam logic CPOL_RESET = 1'b1;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 1 + BUF_ADDR_BITS + 8;

    typedef enum logic [13:0] {
        CMD_NONE = 14'h0001, CMD_CONT_READ = 14'h0002, CMD_PAGE_READ = 14'h0004,
        CMD_BUF_READ = 14'h0008, CMD_STATUS = 14'h0010, CMD_BUF_WRITE = 14'h0020,
        CMD_PROG_ERASE = 14'h0040, CMD_PROG_PLAIN = 14'h0080, CMD_PAGE_ERASE = 14'h0100,
        CMD_BLOCK_ERASE = 14'h0200, CMD_PROG_THRU = 14'h0400, CMD_XFER = 14'h0800,
        CMD_COMPARE = 14'h1000, CMD_REWRITE = 14'h2000
    } sfc_cmd_type;

    typedef enum logic [2:0] {S_IDLE = 3'h1, S_SHIFT = 3'h2, S_IGNORE = 3'h4} sfc_sess_type;
    typedef enum logic [2:0] {O_IDLE = 3'h1, O_DRAIN = 3'h2, O_RUN = 3'h4} sfc_op_type;

    function automatic sfc_cmd_type decodeOpcode(input logic [7:0] opc);
        case (opc)
            8'h68, 8'he8: return CMD_CONT_READ;
            8'h52, 8'hd2: return CMD_PAGE_READ;
            8'h54, 8'hd4, 8'h56, 8'hd6: return CMD_BUF_READ;
            8'h57, 8'hd7: return CMD_STATUS;
            8'h84, 8'h87: return CMD_BUF_WRITE;
            8'h83, 8'h86: return CMD_PROG_ERASE;
            8'h88, 8'h89: return CMD_PROG_PLAIN;
            8'h82, 8'h85: return CMD_PROG_THRU;
            8'h81: return CMD_PAGE_ERASE;
            8'h50: return CMD_BLOCK_ERASE;
            8'h53, 8'h55: return CMD_XFER;
            8'h60, 8'h61: return CMD_COMPARE;
            8'h58, 8'h59: return CMD_REWRITE;
            default: return CMD_NONE;
        endcase
    endfunction : decodeOpcode

    // second buffer is selected by these opcodes
    function automatic logic bufferTwo(input logic [7:0] opc);
        case (opc)
            8'h56, 8'hd6, 8'h87, 8'h86, 8'h89, 8'h85, 8'h55, 8'h61, 8'h59: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : bufferTwo

    function automatic logic isReadCmd(input sfc_cmd_type k);
        return k inside {CMD_CONT_READ, CMD_PAGE_READ, CMD_BUF_READ, CMD_STATUS};
    endfunction : isReadCmd

    function automatic logic isSelfTimed(input sfc_cmd_type k);
        return k inside {CMD_PROG_ERASE, CMD_PROG_PLAIN, CMD_PAGE_ERASE, CMD_BLOCK_ERASE,
                         CMD_PROG_THRU, CMD_XFER, CMD_COMPARE, CMD_REWRITE};
    endfunction : isSelfTimed

    function automatic logic isArrayCmd(input sfc_cmd_type k);
        return isSelfTimed(k) || k inside {CMD_CONT_READ, CMD_PAGE_READ};
    endfunction : isArrayCmd

    function automatic logic isProgram(input sfc_cmd_type k);
        return isSelfTimed(k) && !(k inside {CMD_XFER, CMD_COMPARE});
    endfunction : isProgram

    function automatic logic engagesBuffer(input sfc_cmd_type k);
        return isSelfTimed(k) && !(k inside {CMD_PAGE_ERASE, CMD_BLOCK_ERASE});
    endfunction : engagesBuffer

    function automatic logic [15:0] dataStart(input sfc_cmd_type k);
        case (k)
            CMD_STATUS: return 16'(OPCODE_BITS);
            CMD_BUF_READ: return 16'(BUF_DATA_START);
            default: return 16'(ARRAY_DATA_START);
        endcase
    endfunction : dataStart
endpackage : sfc_pkg

// File: tb/sfc_front_end_tb.sv
`timescale 1ns/1ps
module sfc_front_end_tb;
    import sfc_pkg::*;
    logic clock, reset, csN, sck, si, so, soOe, wpN, resetN, busyOut, busyOe, spiModeHigh;
    logic opStart, opBuffer, opAbort, opDone, compareMismatch, rdReq, rdFromArray, rdBuffer;
    logic wrValid, wrReady, wrBuffer, writeOverrun;
    logic [13:0] opKind, kindSeen;
    logic [PAGE_BITS-1:0] opPage, rdPage, pageSeen;
    logic [BUF_ADDR_BITS-1:0] rdAddr, wrAddr, lastAddr;
    logic [7:0] wrData, lastData, rd;
    logic lastBuf;
    int errCount = 0, nChecks = 0, starts = 0, acc = 0, engDelay = 10;
    // a floating output shows the inverse of the last value to the host
    sfc_host i_host (.clock(clock), .so(soOe ? so : ~so), .csN(csN), .sck(sck), .si(si));
    sfc_front_end i_dut (.clock(clock), .reset(reset), .csN(csN), .sck(sck), .si(si),
        .so(so), .soOe(soOe), .wpN(wpN), .resetN(resetN), .busyOut(busyOut),
        .busyOe(busyOe), .spiModeHigh(spiModeHigh), .opStart(opStart), .opKind(opKind),
        .opPage(opPage), .opBuffer(opBuffer), .opAbort(opAbort), .opDone(opDone),
        .compareMismatch(compareMismatch), .rdReq(rdReq), .rdFromArray(rdFromArray),
        .rdBuffer(rdBuffer), .rdPage(rdPage), .rdAddr(rdAddr), .rdData(rdAddr[7:0] ^ 8'h3c),
        .wrValid(wrValid), .wrReady(wrReady), .wrBuffer(wrBuffer), .wrAddr(wrAddr),
        .wrData(wrData), .writeOverrun(writeOverrun));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // array engine and buffer sink stand-ins
    always @(posedge clock) begin
        if (wrValid === 1'b1 && wrReady === 1'b1) begin
            acc++;
            {lastBuf, lastAddr, lastData} = {wrBuffer, wrAddr, wrData};
        end
    end
    // the engine waits in its own process so buffer writes are still seen
    always @(posedge clock) begin
        if (opStart === 1'b1) begin
            starts++;
            {kindSeen, pageSeen} = {opKind, opPage};
            repeat (engDelay) @(posedge clock);
            #1 opDone = 1'b1;
            @(posedge clock);
            #1 opDone = 1'b0;
        end
    end
    task automatic check(string name, logic [15:0] got, logic [15:0] exp);
        nChecks++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic go(logic [7:0] opc, logic [11:0] pg);
        i_host.frame(opc, {2'b00, pg, 10'h000}, 24, 0, 8'h00, rd);
        repeat (10) @(posedge clock);
    endtask : go
    task automatic status(logic [15:0] exp, logic [7:0] msk, string n);
        i_host.frame(8'hd7, 24'h0, 0, 1, 8'h00, rd);
        check(n, 16'(rd & msk), exp);
        check("soOe idle", 16'(soOe), 16'h0);
    endtask : status
    task automatic tWrite;
        #1 wrReady = 1'b0;
        i_host.frame(8'h84, 24'h000005, 24, 9, 8'ha0, rd);
        check("overrun", 16'(writeOverrun), 16'h1);
        #1 wrReady = 1'b1;
        repeat (12) @(posedge clock);
        check("accepted", 16'(acc), 16'h8);
        check("last", {lastBuf, lastAddr[6:0], lastData}, {1'b0, 7'd12, 8'ha7});
    endtask : tWrite
    task automatic tBusy;
        int a;
        engDelay = 900;
        go(8'h83, 12'h123);
        check("busy", 16'({busyOe, opBuffer, pageSeen}), 16'h2123);
        status(16'h0, 8'h80, "ready");
        a = acc;
        i_host.frame(8'h84, 24'h000000, 24, 1, 8'h77, rd);
        i_host.frame(8'h87, 24'h000000, 24, 1, 8'h55, rd);
        repeat (4) @(posedge clock);
        check("one write", 16'(acc - a), 16'h1);
        check("other buf", 16'({lastBuf, lastData}), 16'h155);
        repeat (700) @(posedge clock);
        check("idle", 16'(busyOe), 16'h0);
        engDelay = 10;
    endtask : tBusy
    task automatic tProtect;
        int s;
        #1 wpN = 1'b0;
        s = starts;
        go(8'h81, 12'h0ff);
        check("refused", 16'(starts - s), 16'h0);
        go(8'h81, 12'h100);
        check("allowed", 16'(starts - s), 16'h1);
        #1 wpN = 1'b1;
    endtask : tProtect
    task automatic tKinds;
        logic [7:0] oc[14] = '{8'h83, 8'h86, 8'h88, 8'h89, 8'h81, 8'h50, 8'h82, 8'h85,
                               8'h53, 8'h55, 8'h60, 8'h61, 8'h58, 8'h59};
        for (int i = 0; i < 14; i++) begin
            go(oc[i], 12'h200);
            check("kind", 16'(kindSeen), 16'(14'h0040 << ((i < 5) ? i / 2 : i / 2 + 1)));
        end
    endtask : tKinds
    task automatic tAbort;
        engDelay = 600;
        go(8'h81, 12'h300);
        #1 resetN = 1'b0;
        repeat (6) @(posedge clock);
        check("abort", 16'({opAbort, busyOe, spiModeHigh, soOe}), 16'ha);
        #1 resetN = 1'b1;
        repeat (650) @(posedge clock);
        engDelay = 10;
    endtask : tAbort
    task automatic tRead;
        i_host.frame(8'hd6, 24'h000007, 24, 2, 8'h00, rd);
        check("buf read", 16'({rdFromArray, rdBuffer, rd}), 16'h13b);
    endtask : tRead
    task automatic tMode;
        i_host.idle = 1'b0;
        i_host.frame(8'hd2, 24'h02ac11, 24, 5, 8'h00, rd);
        check("mode 0", 16'({spiModeHigh, rdPage}), 16'h00ab);
        check("page read", 16'({rdFromArray, rd}), 16'h12d);
        i_host.idle = 1'b1;
        status(16'h80, 8'h80, "mode 3");
        check("mode 3", 16'(spiModeHigh), 16'h1);
    endtask : tMode
    initial begin
        {reset, opDone, wrReady, wpN, resetN, compareMismatch} = 6'b100111;
        repeat (3) @(posedge clock);
        // the supply is taken as settled long before this point
        #1 reset = 1'b0;
        check("reset", 16'({spiModeHigh, soOe, busyOe, busyOut}), 16'h8);
        status(16'h80, 8'hc0, "status");
        tWrite();
        tBusy();
        tProtect();
        tKinds();
        status(16'h40, 8'h40, "compare");
        tRead();
        tMode();
        tAbort();
        conclude();
    end
    initial begin
        repeat (90000) @(posedge clock);
        errCount++;
        conclude();
    end
endmodule : sfc_front_end_tb

// File: tb/sfc_host.sv
`timescale 1ns/1ps
module sfc_host (
    input wire logic clock,
    input wire logic so,
    output logic csN,
    output logic sck,
    output logic si
);
    // idle level of sck: 1 for mode 3, 0 for mode 0
    logic idle = 1'b1;
    initial begin
        csN = 1'b1;
        sck = 1'b1;
        si = 1'b0;
    end
    // sck is left high after each frame and set to its idle level before select falls, 800 ns period
    task automatic frame(input logic [7:0] opc, input logic [23:0] adr, input int nh,
                         input int nb, input logic [7:0] d, output logic [7:0] rd);
        logic [31:0] h;
        logic [7:0] b;
        int j;
        h = {opc, adr};
        rd = 8'h00;
        @(posedge clock);
        #1 sck = idle;
        @(posedge clock);
        #1 csN = 1'b0;
        repeat (4) @(posedge clock);
        for (int i = 0; i < 8 + nh + 8 * nb; i++) begin
            j = i - 8 - nh;
            b = d + 8'(j / 8);
            #1 sck = 1'b0;
            si = (i < 8 + nh) ? h[31 - i] : b[7 - j % 8];
            repeat (4) @(posedge clock);
            #1 sck = 1'b1;
            repeat (3) @(posedge clock);
            rd = {rd[6:0], so};
            @(posedge clock);
        end
        #1 si = ~si;
        csN = 1'b1;
        repeat (8) @(posedge clock);
    endtask : frame
endmodule : sfc_host
